// ==== pme_paging.v ====
/*
 * Paged memory expansion unit: two windows mapped onto external banks
 * through six expansion lines shared with a general-purpose port.
 * Assumes a one-cycle register port, synchronous CPU address and
 * internal-resource flags supplied by the surrounding address decoder.
 * Every output is registered, so pins and selects trail the CPU address
 * by one clock; the surrounding bus timing must allow for that cycle.
 * Chip-select generation is not part of this block.
 */
// Design decision made here: strobed register access.
// What this block does
// - Two windows, each off, 8K, 16K or 32K
// - Bank lines choose bank, CPU lines byte
// - Used low lines replace CPU address bits
// - Offset width follows window size
// - Base multiple of size, 32K also 0x4000
// - Special 32K window inverts line 14 on hit
// - Window 1 wins where windows overlap
// - Internal registers RAM EEPROM in every bank
// - ROM responds only when bank bits 18:16 zero
// - Reset vector external at 7FFE when paged
// - Pin role bits pick GPIO or bank line
// - Unused bank bit leaves pin for GPIO
// - Assigned unused low line outputs CPU bit
// - Per-window bank registers select visible bank
// - Size register at 0x56 holds both sizes
// - Size field 00 off 01 8K 10 16K 11 32K
// - Base register at 0x57 holds bits 15:13
// - Hit window's bank bits drive assigned lines
`timescale 1ns/1ps
`include "pme_consts.vh"

module pme_paging (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [15:0] cpu_addr,
  input  wire        internal_hit,
  input  wire        rom_hit,
  input  wire        rom_enabled,
  input  wire        rom_relocated,
  input  wire [5:0]  gpio_out,
  input  wire [5:0]  gpio_oe,
  output reg  [5:0]  port_pin_out,
  output reg  [5:0]  port_pin_oe,
  output reg  [15:13] mem_addr_high,
  output reg  [5:0]  bank_address_lines,
  output reg         external_select,
  output reg         rom_select,
  output reg  [15:0] reset_vector_addr
);

  // Software-visible registers
  reg [7:0] port_pin_role_assign;
  reg [7:0] window_size_select;
  reg [7:0] window_base_select;
  reg [7:0] window1_bank_select;
  reg [7:0] window2_bank_select;

  // Combinational decode results
  wire       hit1_raw;
  wire       hit2_raw;
  wire       spec1;
  wire       spec2;
  reg        hit1;
  reg        hit2;
  reg        spec_hit;
  reg [1:0]  hit_size;
  reg [5:0]  used_mask;
  reg [5:0]  next_lines;
  reg [5:0]  next_pin_out;
  reg [5:0]  next_pin_oe;
  reg [15:13] next_high;
  reg        next_ext;
  reg        next_rom;
  reg [15:0] next_vec;
  reg [7:0]  next_rdata;

  wire [1:0] window1_size_field = window_size_select[`PME_SZ1_LSB+1:`PME_SZ1_LSB];
  wire [1:0] window2_size_field = window_size_select[`PME_SZ2_LSB+1:`PME_SZ2_LSB];
  wire [2:0] window1_base_field = window_base_select[`PME_BASE1_LSB+2:`PME_BASE1_LSB];
  wire [2:0] window2_base_field = window_base_select[`PME_BASE2_LSB+2:`PME_BASE2_LSB];
  wire [5:0] window1_bank_bits  = window1_bank_select[5:0];
  wire [5:0] window2_bank_bits  = window2_bank_select[5:0];

  // Expansion lines a window of this size uses (bit 0 is line 13)
  function [5:0] pme_used_lines;
    input [1:0] size_field;
    input       special;
    begin
      // The 0x4000 case needs line 14 as well, since it carries the
      // inverted offset bit instead of a bank bit
      case (size_field)
        `PME_SZ_8K:  pme_used_lines = 6'h3F;
        `PME_SZ_16K: pme_used_lines = 6'h3E;
        `PME_SZ_32K: pme_used_lines = special ? 6'h3E : 6'h3C;
        default:     pme_used_lines = 6'h00;
      endcase
    end
  endfunction

  // A window counts as enabled for any size code but off
  function pme_window_on;
    input [1:0] size_field;
    begin
      pme_window_on = (size_field != `PME_SZ_OFF);
    end
  endfunction

  pme_window_match u_win1 (
    .cpu_addr          (cpu_addr),
    .window_size_field (window1_size_field),
    .window_base_field (window1_base_field),
    .hit               (hit1_raw),
    .special_base      (spec1)
  );

  pme_window_match u_win2 (
    .cpu_addr          (cpu_addr),
    .window_size_field (window2_size_field),
    .window_base_field (window2_base_field),
    .hit               (hit2_raw),
    .special_base      (spec2)
  );

  // Window 1 always wins; window 2 answers only outside window 1
  always @* begin
    hit1     = hit1_raw;
    hit2     = hit2_raw & ~hit1_raw;
    spec_hit = (hit1 & spec1) | (hit2 & spec2);
  end

  // Lines either window needs; only the low three matter below,
  // since a high line has no CPU bit to fall back on
  always @* begin
    used_mask = pme_used_lines(window1_size_field, spec1) |
                pme_used_lines(window2_size_field, spec2);
  end

  // Bank lines of the hit window; lines inside the offset go back to the CPU
  always @* begin
    hit_size   = `PME_SZ_OFF;
    next_lines = {3'h0, cpu_addr[15:13]};
    if (hit1) begin
      hit_size   = window1_size_field;
      next_lines = window1_bank_bits;
    end else if (hit2) begin
      hit_size   = window2_size_field;
      next_lines = window2_bank_bits;
    end
    // 16K keeps the CPU's bit 13 as part of the byte offset
    if (hit_size == `PME_SZ_16K) begin
      next_lines[0] = cpu_addr[13];
    end
    // 32K on a size multiple keeps bits 14:13 from the CPU
    if ((hit_size == `PME_SZ_32K) && !spec_hit) begin
      next_lines[1:0] = cpu_addr[14:13];
    end
    // 32K at 0x4000: memory bit 14 must come from line 14, inverted,
    // or the window would not be contiguous in the memory device
    if (spec_hit) begin
      next_lines[0] = cpu_addr[13];
      next_lines[1] = ~cpu_addr[14];
    end
  end

  // Expanded address: used low lines replace the CPU's bits 15:13
  always @* begin
    next_high = cpu_addr[15:13];
    if (hit1 | hit2) begin
      next_high = next_lines[2:0];
    end
  end

  // Pin roles: assigned pins carry lines, all others stay with the port
  always @* begin
    next_pin_out = gpio_out;
    next_pin_oe  = gpio_oe;
    // Line 13: CPU bit 13 when neither window uses it
    if (port_pin_role_assign[0]) begin
      next_pin_out[0] = used_mask[0] ? next_lines[0] : cpu_addr[13];
      next_pin_oe[0]  = 1'b1;
    end
    // Line 14: CPU bit 14 when neither window uses it
    if (port_pin_role_assign[1]) begin
      next_pin_out[1] = used_mask[1] ? next_lines[1] : cpu_addr[14];
      next_pin_oe[1]  = 1'b1;
    end
    // Line 15: CPU bit 15 when neither window uses it
    if (port_pin_role_assign[2]) begin
      next_pin_out[2] = used_mask[2] ? next_lines[2] : cpu_addr[15];
      next_pin_oe[2]  = 1'b1;
    end
    // Lines 16 to 18 have no CPU bit; they read low on a miss
    if (port_pin_role_assign[3]) begin
      next_pin_out[3] = next_lines[3];
      next_pin_oe[3]  = 1'b1;
    end
    if (port_pin_role_assign[4]) begin
      next_pin_out[4] = next_lines[4];
      next_pin_oe[4]  = 1'b1;
    end
    if (port_pin_role_assign[5]) begin
      next_pin_out[5] = next_lines[5];
      next_pin_oe[5]  = 1'b1;
    end
  end

  // Internal resources shadow every bank; ROM only in bank group 0
  always @* begin
    next_rom = rom_hit & (~(hit1 | hit2) | (next_lines[5:3] == 3'h0));
    next_ext = (hit1 | hit2) & ~internal_hit & ~next_rom;
  end

  // Paging moves the reset vector into external space; with paging off
  // the ROM flags only decide who answers, not the address
  always @* begin
    if (pme_window_on(window1_size_field) || pme_window_on(window2_size_field)) begin
      next_vec = `PME_VEC_PAGED;
    end else begin
      next_vec = `PME_VEC_PLAIN;
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    next_rdata = 8'h00;
    if (reg_addr == `PME_OFS_PIN_ROLE) begin
      // Six pins only; the top bits have nothing behind them
      next_rdata = {2'h0, port_pin_role_assign[5:0]};
    end else if (reg_addr == `PME_OFS_SIZE) begin
      // Two size fields with unused pairs between them
      next_rdata = {2'h0, window_size_select[5:4], 2'h0, window_size_select[1:0]};
    end else if (reg_addr == `PME_OFS_BASE) begin
      // Base bits 15:13 of each window, gap bits read zero
      next_rdata = {window_base_select[7:5], 1'h0, window_base_select[3:1], 1'h0};
    end else if (reg_addr == `PME_OFS_BANK1) begin
      // Window 1 bank, lines 18:13
      next_rdata = {2'h0, window1_bank_select[5:0]};
    end else if (reg_addr == `PME_OFS_BANK2) begin
      // Window 2 bank, lines 18:13
      next_rdata = {2'h0, window2_bank_select[5:0]};
    end else if (reg_addr == `PME_OFS_STATUS) begin
      // Live view: plain ROM off flag plus hit state of last address
      next_rdata = {3'h0, ~rom_enabled | rom_relocated, external_select, rom_select, hit2, hit1};
    end
  end

  // Pin role register; a write takes effect on the pins one cycle later
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_pin_role_assign <= `PME_RST_PIN_ROLE;
    end else if (reg_wr && (reg_addr == `PME_OFS_PIN_ROLE)) begin
      port_pin_role_assign <= {2'h0, reg_wdata[5:0]};
    end
  end

  // Window size register; gap bits are forced to zero on write
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      window_size_select <= `PME_RST_SIZE;
    end else if (reg_wr && (reg_addr == `PME_OFS_SIZE)) begin
      window_size_select <= {2'h0, reg_wdata[5:4], 2'h0, reg_wdata[1:0]};
    end
  end

  // Window base register; gap bits are forced to zero on write
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      window_base_select <= `PME_RST_BASE;
    end else if (reg_wr && (reg_addr == `PME_OFS_BASE)) begin
      window_base_select <= {reg_wdata[7:5], 1'h0, reg_wdata[3:1], 1'h0};
    end
  end

  // Window 1 bank; software switches banks by rewriting it
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      window1_bank_select <= `PME_RST_BANK;
    end else if (reg_wr && (reg_addr == `PME_OFS_BANK1)) begin
      window1_bank_select <= {2'h0, reg_wdata[5:0]};
    end
  end

  // Window 2 bank; software switches banks by rewriting it
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      window2_bank_select <= `PME_RST_BANK;
    end else if (reg_wr && (reg_addr == `PME_OFS_BANK2)) begin
      window2_bank_select <= {2'h0, reg_wdata[5:0]};
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  // Pin drive: registered so the pads never see decode glitches
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_pin_out <= 6'h00;
      port_pin_oe  <= 6'h00;
    end else begin
      port_pin_out <= next_pin_out;
      port_pin_oe  <= next_pin_oe;
    end
  end

  // Memory-side outputs: registered so every output comes from a flip-flop,
  // at the price of one cycle of address-to-pin latency
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr_high      <= 3'h0;
      bank_address_lines <= 6'h00;
      external_select    <= 1'b0;
      rom_select         <= 1'b0;
      reset_vector_addr  <= `PME_VEC_PLAIN;
    end else begin
      mem_addr_high      <= next_high;
      bank_address_lines <= next_lines;
      external_select    <= next_ext;
      rom_select         <= next_rom;
      reset_vector_addr  <= next_vec;
    end
  end

endmodule

// ==== pme_consts.vh ====
/*
 * Constants for the paged memory expansion unit: register offsets,
 * field positions, reset values and fixed addresses.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef PME_CONSTS_VH
`define PME_CONSTS_VH

`define PME_OFS_PIN_ROLE      8'h2D
`define PME_OFS_SIZE          8'h56
`define PME_OFS_BASE          8'h57
`define PME_OFS_BANK1         8'h58
`define PME_OFS_BANK2         8'h59
`define PME_OFS_STATUS        8'h5A

`define PME_RST_PIN_ROLE      8'h00
`define PME_RST_SIZE          8'h00
`define PME_RST_BASE          8'h00
`define PME_RST_BANK          8'h00

`define PME_SZ1_LSB           0
`define PME_SZ2_LSB           4
`define PME_BASE1_LSB         1
`define PME_BASE2_LSB         5

`define PME_SZ_OFF            2'h0
`define PME_SZ_8K             2'h1
`define PME_SZ_16K            2'h2
`define PME_SZ_32K            2'h3

`define PME_BASE_SPECIAL      3'h2
`define PME_VEC_PAGED         16'h7FFE
`define PME_VEC_PLAIN         16'hFFFE

`endif

// ==== pme_window_match.v ====
/*
 * Window hit decoder: compares a CPU address with one window's size and
 * base fields and reports a hit plus whether the 0x4000 32K case is active.
 * Assumes pure combinational use by the paging top.
 */
`timescale 1ns/1ps
`include "pme_consts.vh"

module pme_window_match (
  input  wire [15:0] cpu_addr,
  input  wire [1:0]  window_size_field,
  input  wire [2:0]  window_base_field,
  output reg         hit,
  output reg         special_base
);

  // Base must be a size multiple; 32K may also sit at 0x4000
  always @* begin
    hit          = 1'b0;
    special_base = 1'b0;
    case (window_size_field)
      `PME_SZ_8K: begin
        hit = (cpu_addr[15:13] == window_base_field);
      end
      `PME_SZ_16K: begin
        hit = (cpu_addr[15:14] == window_base_field[2:1]);
      end
      `PME_SZ_32K: begin
        if (window_base_field == `PME_BASE_SPECIAL) begin
          special_base = 1'b1;
          hit = (cpu_addr[15:14] == 2'h1) || (cpu_addr[15:14] == 2'h2);
        end else begin
          hit = (cpu_addr[15] == window_base_field[2]);
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

endmodule

// ==== pme_paging_assertions.sv ====
/* Port checker for the paging unit.
   Assumes one clock domain and a bind onto each unit. */
`timescale 1ns/1ps
module pme_chk (
  input logic         clk_sys,
  input logic         rst_b,
  input logic [7:0]   reg_addr,
  input logic [7:0]   reg_wdata,
  input logic         reg_wr,
  input logic         reg_rd,
  input logic [7:0]   reg_rdata,
  input logic         internal_hit,
  input logic         rom_hit,
  input logic [15:13] mem_addr_high,
  input logic [5:0]   bank_address_lines,
  input logic         external_select,
  input logic         rom_select,
  input logic [15:0]  reset_vector_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Bus, vector and select relations
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  vec_paged_a: assert property (reg_wr && reg_addr == 8'h56 && (reg_wdata & 8'h33) != 8'h00
    |-> ##[1:2] reset_vector_addr == 16'h7FFE) else $error("vector not paged");
  vec_plain_a: assert property (reg_wr && reg_addr == 8'h56 && (reg_wdata & 8'h33) == 8'h00
    |-> ##[1:2] reset_vector_addr == 16'hFFFE) else $error("vector not plain");
  rom_bank_a: assert property (rom_select |-> bank_address_lines[5:3] == 3'h0)
    else $error("rom outside bank zero");
  rom_cause_a: assert property (rom_select |-> $past(rom_hit))
    else $error("rom select without rom range");
  internal_local_a: assert property ($past(internal_hit) |-> !external_select)
    else $error("external select on internal");
  high_match_a: assert property (mem_addr_high == bank_address_lines[2:0])
    else $error("high address differs from lines");
  sel_excl_a: assert property (!(rom_select && external_select))
    else $error("rom and external both selected");
  cover property (external_select);
  cover property (rom_select);
  cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind pme_paging pme_chk u_chk (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .internal_hit, .rom_hit, .mem_addr_high, .bank_address_lines, .external_select, .rom_select,
  .reset_vector_addr);

// ==== pme_ext_mem.sv ====
/* Behavioural external paged memory.
   Assumes registered lines and select from the paging unit. */
`timescale 1ns/1ps
module pme_ext_mem (
  input logic        clk_sys,
  input logic [5:0]  bank_address_lines,
  input logic [15:0] cpu_addr,
  input logic        external_select,
  output logic [7:0] mem_data
);
  logic [7:0] cur;
  logic [7:0] last = 8'h00;
  // Byte pattern from bank and low address
  assign cur = {bank_address_lines, cpu_addr[1:0]};
  // Deselected bus shows the inverse so stale data never looks valid
  always @(posedge clk_sys) begin
    if (external_select) begin
      last <= cur;
    end
  end
  assign mem_data = external_select ? cur : ~last;
endmodule

// ==== tb_pme_paging.sv ====
/* Testbench for the paging unit.
   Assumes the checker binds itself to the unit. */
`timescale 1ns/1ps
module tb_pme_paging;
  logic         clk_sys = 1'b0;
  logic         rst_b = 1'b0;
  logic [7:0]   reg_addr = 8'h00;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [15:0]  cpu_addr = 16'h0000;
  logic         internal_hit = 1'b0;
  logic         rom_hit = 1'b0;
  logic         rom_enabled = 1'b1;
  logic         rom_relocated = 1'b0;
  logic [5:0]   gpio_out = 6'h2A;
  logic [5:0]   gpio_oe = 6'h28;
  logic [7:0]   reg_rdata;
  logic [5:0]   port_pin_out;
  logic [5:0]   port_pin_oe;
  logic [15:13] mem_addr_high;
  logic [5:0]   bank_address_lines;
  logic         external_select;
  logic         rom_select;
  logic [15:0]  reset_vector_addr;
  logic [7:0]   mem_data;
  int           failures = 0;
  int           checks_done = 0;
  always #10 clk_sys = ~clk_sys;
  pme_paging DUT (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_addr,
    .internal_hit, .rom_hit, .rom_enabled, .rom_relocated, .gpio_out, .gpio_oe, .port_pin_out,
    .port_pin_oe, .mem_addr_high, .bank_address_lines, .external_select, .rom_select, .reset_vector_addr);
  pme_ext_mem u_mem (.clk_sys, .bank_address_lines, .cpu_addr, .external_select, .mem_data);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data are judged in the one cycle they stand
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(16'(reg_rdata), 16'(e));
  endtask
  // Decode answers one edge after the address lands
  task automatic pl(input logic [15:0] a, input logic ih, input logic rh, input logic [5:0] e);
    @(posedge clk_sys);
    cpu_addr <= a;
    internal_hit <= ih;
    rom_hit <= rh;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(16'(bank_address_lines), 16'(e));
  endtask
  task automatic t_regs();
    chk(reset_vector_addr, 16'hFFFE);
    rd(8'h56, 8'h00);
    wr(8'h56, 8'h31);
    rd(8'h56, 8'h31);
    wr(8'h57, 8'hEE);
    rd(8'h57, 8'hEE);
    wr(8'h58, 8'h3F);
    rd(8'h58, 8'h3F);
    wr(8'h59, 8'h15);
    rd(8'h59, 8'h15);
    wr(8'h2D, 8'h3F);
    rd(8'h2D, 8'h3F);
    rd(8'h40, 8'h00);
  endtask
  task automatic t_win();
    wr(8'h57, 8'h02);
    wr(8'h58, 8'h2A);
    wr(8'h56, 8'h01);
    pl(16'h3123, 1'b0, 1'b0, 6'h2A);
    chk(16'(mem_addr_high), 16'h2);
    chk(16'(port_pin_out), 16'h2A);
    chk(16'(mem_data), 16'hAB);
    chk(reset_vector_addr, 16'h7FFE);
    pl(16'h5000, 1'b0, 1'b0, 6'h02);
    chk(16'(external_select), 16'h0);
    wr(8'h56, 8'h03);
    wr(8'h57, 8'h04);
    wr(8'h58, 8'h3C);
    pl(16'h8000, 1'b0, 1'b0, 6'h3E);
    pl(16'h4000, 1'b0, 1'b0, 6'h3C);
    pl(16'hC000, 1'b0, 1'b0, 6'h06);
  endtask
  task automatic t_ovl();
    wr(8'h56, 8'h21);
    wr(8'h57, 8'h02);
    wr(8'h58, 8'h05);
    wr(8'h59, 8'h31);
    pl(16'h2000, 1'b0, 1'b0, 6'h05);
    pl(16'h0000, 1'b0, 1'b0, 6'h30);
    pl(16'h2000, 1'b1, 1'b0, 6'h05);
    chk(16'(external_select), 16'h0);
    pl(16'h2000, 1'b0, 1'b1, 6'h05);
    chk(16'(rom_select), 16'h1);
    rd(8'h5A, 8'h05);
    wr(8'h58, 8'h30);
    pl(16'h2000, 1'b0, 1'b1, 6'h30);
    chk(16'(rom_select), 16'h0);
  endtask
  // Low lines assigned but unused still carry the CPU bits
  task automatic t_pins();
    wr(8'h56, 8'h00);
    wr(8'h2D, 8'h07);
    pl(16'hA000, 1'b0, 1'b0, 6'h05);
    chk(16'(port_pin_out), 16'h2D);
    chk(16'(port_pin_oe), 16'h2F);
    chk(reset_vector_addr, 16'hFFFE);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_win();
    t_ovl();
    t_pins();
    tally_and_finish();
  end
  // Whole run needs under a hundred cycles; this is ample margin
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
